/* design/gg_status_defs.vh */
// Operation
// - Status word: status low, configuration high
// - Configuration byte comes from flash 0x28
// - Status bits ordered presence down to under-limit
// - Presence bit follows pack insertion
// - Low-voltage warning at second end-of-discharge threshold
// - Seal bit follows sealed state
// - Link failure bit follows front-end communication
// - Discharge qualification bit follows cycle validity
// - Failure bit set at 0x66, cleared at 0x00
// - Over-limit bit mirrors present faults, unlatched
// - Under-limit bit mirrors present faults, unlatched
// - Four cell voltages at codes 0x3c-0x3f
// - Alternate select moves cells to 0x38-0x3b
// - Unselected cell code set is refused
// - Flash read at reset, written for history
// - Words high byte first; strings length-prefixed
// - Read-word returns 16-bit unsigned value
`ifndef GG_STATUS_DEFS_VH
`define GG_STATUS_DEFS_VH

// Command codes
`define GG_CMD_STATUS 8'h2f
`define GG_CMD_CELL_BASE 8'h3c
`define GG_CMD_CELL_ALT_BASE 8'h38

// Status byte bit positions
`define GG_ST_PRESENT 7
`define GG_ST_LOW_VOLT 6
`define GG_ST_SEALED 5
`define GG_ST_DSG_QUAL 4
`define GG_ST_LINK_FAIL 3
`define GG_ST_PERM_FAIL 2
`define GG_ST_OVER_LIM 1
`define GG_ST_UNDER_LIM 0

// Failure flag byte values
`define GG_FAIL_SET_VAL 8'h66
`define GG_FAIL_CLR_VAL 8'h00

// Flash locations
`define GG_DF_NAME_LEN 8'h0e
`define GG_DF_DEVNAME_LEN 8'h1a
`define GG_DF_CHEM_LEN 8'h22
`define GG_DF_PACK_CFG 8'h28
`define GG_DF_LOW_VOLTAGE_WARNING_HI 8'h99
`define GG_DF_LOW_VOLTAGE_WARNING_LO 8'h9a
`define GG_DF_MISC2 8'hb0

// Second miscellaneous configuration fields
`define GG_MISC2_ALT_CELL 0
`define GG_MISC2_CELL_MON 1

// Reset values of the loaded shadows
`define GG_PACK_CFG_RST 8'h00
`define GG_MISC2_RST 8'h00
`define GG_LOW_VOLTAGE_WARNING_RST 16'h0000

// Shipped example contents
`define GG_PACK_CFG_DFLT 8'hc3
`define GG_LOW_VOLTAGE_WARNING_HI_DFLT 8'h0d
`define GG_LOW_VOLTAGE_WARNING_LO_DFLT 8'h48
`define GG_NAME_LEN_DFLT 8'h0b
`define GG_DEVNAME_LEN_DFLT 8'h06
`define GG_CHEM_LEN_DFLT 8'h04

// Loader
`define GG_LOAD_STEPS 2'd3

`endif

/* design/gg_data_flash.v */
`include "gg_status_defs.vh"
`default_nettype none

module gg_data_flash #(
	parameter ADDR_W = 8,
	parameter DATA_W = 8
) (
	// Clock
	input wire sys_clk,
	input wire clkEn,
	// Read port, data one cycle after the request
	input wire rdEn,
	input wire [ADDR_W-1:0] rdAddr,
	output reg [DATA_W-1:0] rdData,
	// Write port
	input wire wrEn,
	input wire [ADDR_W-1:0] wrAddr,
	input wire [DATA_W-1:0] wrData
);

	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	integer i;

	// Example pack image; word parameters are stored high byte first
	initial begin
		for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
			mem[i] = {DATA_W{1'b0}};
		end
		mem[`GG_DF_NAME_LEN] = `GG_NAME_LEN_DFLT;
		mem[`GG_DF_DEVNAME_LEN] = `GG_DEVNAME_LEN_DFLT;
		mem[`GG_DF_CHEM_LEN] = `GG_CHEM_LEN_DFLT;
		mem[`GG_DF_PACK_CFG] = `GG_PACK_CFG_DFLT;
		mem[`GG_DF_LOW_VOLTAGE_WARNING_HI] = `GG_LOW_VOLTAGE_WARNING_HI_DFLT;
		mem[`GG_DF_LOW_VOLTAGE_WARNING_LO] = `GG_LOW_VOLTAGE_WARNING_LO_DFLT;
	end

	always @(posedge sys_clk) begin
		if (clkEn) begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			if (rdEn) begin
				rdData <= mem[rdAddr];
			end
		end
	end

endmodule // gg_data_flash

`default_nettype wire

/* design/gg_pack_status.v */
`include "gg_status_defs.vh"
`default_nettype none

module gg_pack_status #(
	parameter VOLT_W = 16
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	input wire clkEn,
	// Pack presence pin, asynchronous
	input wire packPresentPin,
	// Monitored voltages, same clock domain
	input wire [VOLT_W-1:0] monPackVolt,
	input wire [VOLT_W-1:0] monCellVolt,
	// Gauge state, same clock domain
	input wire sealed,
	input wire dischargeQualified,
	input wire frontEndLinkFailed,
	input wire [7:0] failureFlagByte,
	// Present protection faults
	input wire prolongedOverCurrent,
	input wire overVoltage,
	input wire overTemp,
	input wire overload,
	input wire overDischarge,
	// Calculated cell voltages in mV
	input wire [VOLT_W-1:0] cellVolt1,
	input wire [VOLT_W-1:0] cellVolt2,
	input wire [VOLT_W-1:0] cellVolt3,
	input wire [VOLT_W-1:0] cellVolt4,
	// Read-word command
	input wire cmdValid,
	input wire [7:0] cmdCode,
	output reg rspValid,
	output reg rspAck,
	output reg [15:0] rspData,
	// Flash write for history and reprogramming
	input wire dfWrEn,
	input wire [7:0] dfWrAddr,
	input wire [7:0] dfWrData,
	// State
	output reg cfgLoaded,
	output reg [15:0] statusWord
);

	localparam ST_ISSUE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_RUN = 2'd2;

	// Command classes
	localparam CLS_UNKNOWN = 2'd0;
	localparam CLS_STATUS = 2'd1;
	localparam CLS_CELL = 2'd2;
	localparam CLS_UNSEL = 2'd3;

	// Flash addresses read by the loader, in order
	function [7:0] loadAddr;
		input [1:0] idx;
		begin
			case (idx)
			2'd0: loadAddr = `GG_DF_PACK_CFG;
			2'd1: loadAddr = `GG_DF_MISC2;
			2'd2: loadAddr = `GG_DF_LOW_VOLTAGE_WARNING_HI;
			2'd3: loadAddr = `GG_DF_LOW_VOLTAGE_WARNING_LO;
			default: loadAddr = `GG_DF_PACK_CFG;
			endcase
		end
	endfunction

	// Cell value for an offset within a set; the lowest code is cell 4
	function [VOLT_W-1:0] cellPick;
		input [1:0] ofs;
		input [VOLT_W-1:0] c1;
		input [VOLT_W-1:0] c2;
		input [VOLT_W-1:0] c3;
		input [VOLT_W-1:0] c4;
		begin
			case (ofs)
			2'd0: cellPick = c4;
			2'd1: cellPick = c3;
			2'd2: cellPick = c2;
			2'd3: cellPick = c1;
			default: cellPick = c1;
			endcase
		end
	endfunction

	// Whether a code falls in the four-code set starting at base
	function inSet;
		input [7:0] code;
		input [7:0] base;
		begin
			inSet = (code[7:2] == base[7:2]);
		end
	endfunction

	// Sort a code into status, selected cell set, unselected set or unknown
	function [1:0] cmdClass;
		input [7:0] code;
		input [7:0] selB;
		input [7:0] unselB;
		begin
			if (code == `GG_CMD_STATUS) begin
				cmdClass = CLS_STATUS;
			end else if (inSet(code, selB)) begin
				cmdClass = CLS_CELL;
			end else if (inSet(code, unselB)) begin
				cmdClass = CLS_UNSEL;
			end else begin
				cmdClass = CLS_UNKNOWN;
			end
		end
	endfunction

	reg [1:0] stateQ;
	reg [1:0] stateD;
	reg [1:0] loadIdxQ;
	reg [1:0] loadIdxD;
	reg [7:0] packCfgQ;
	reg [7:0] misc2Q;
	reg [15:0] edv2Q;
	reg presSync1Q;
	reg presSync2Q;
	reg presSync3Q;
	reg presentQ;
	reg permFailQ;
	reg permFailD;
	reg lowVoltD;
	reg [7:0] statusByteD;
	reg rspAckD;
	reg [15:0] rspDataD;
	reg fwdHitQ;
	reg [7:0] fwdDataQ;

	wire [7:0] dfRdData;
	wire loadRdEn;
	wire altSel;
	wire [VOLT_W-1:0] monVolt;
	wire [7:0] selBase;
	wire [7:0] unselBase;
	wire [1:0] cellOfs;
	wire [1:0] cmdCls;
	wire [7:0] loadAddrNow;
	wire [7:0] loadByte;

	assign loadRdEn = (stateQ == ST_ISSUE);
	assign altSel = misc2Q[`GG_MISC2_ALT_CELL];
	assign selBase = altSel ? `GG_CMD_CELL_ALT_BASE : `GG_CMD_CELL_BASE;
	assign unselBase = altSel ? `GG_CMD_CELL_BASE : `GG_CMD_CELL_ALT_BASE;
	assign cellOfs = cmdCode[1:0];
	assign cmdCls = cmdClass(cmdCode, selBase, unselBase);
	assign loadAddrNow = loadAddr(loadIdxQ);
	assign loadByte = fwdHitQ ? fwdDataQ : dfRdData;
	// Program option picks pack or cell voltage for the warning
	assign monVolt = misc2Q[`GG_MISC2_CELL_MON] ? monCellVolt : monPackVolt;

	// Configuration store; contents are the manufacturer's to program
	gg_data_flash #(
		.ADDR_W(8),
		.DATA_W(8)
	) uFlash (
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.rdEn(loadRdEn),
		.rdAddr(loadAddrNow),
		.rdData(dfRdData),
		.wrEn(dfWrEn),
		.wrAddr(dfWrAddr),
		.wrData(dfWrData)
	);

	// Loader sequence after reset release
	always @* begin
		stateD = stateQ;
		loadIdxD = loadIdxQ;
		case (stateQ)
		ST_ISSUE: begin
			stateD = ST_WAIT;
		end
		ST_WAIT: begin
			if (loadIdxQ == `GG_LOAD_STEPS) begin
				stateD = ST_RUN;
			end else begin
				loadIdxD = loadIdxQ + 2'd1;
				stateD = ST_ISSUE;
			end
		end
		ST_RUN: begin
			stateD = ST_RUN;
		end
		default: begin
			stateD = ST_ISSUE;
			loadIdxD = 2'd0;
		end
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= ST_ISSUE;
			loadIdxQ <= 2'd0;
			cfgLoaded <= 1'b0;
		end else if (clkEn) begin
			stateQ <= stateD;
			loadIdxQ <= loadIdxD;
			cfgLoaded <= (stateD == ST_RUN);
		end
	end

	// A write to the location being fetched lands after the flash read,
	// so the fetched byte would be stale; forward the written byte instead
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fwdHitQ <= 1'b0;
			fwdDataQ <= 8'h00;
		end else if (clkEn) begin
			fwdHitQ <= loadRdEn & dfWrEn & (dfWrAddr == loadAddrNow);
			fwdDataQ <= dfWrData;
		end
	end

	// Shadows of flash contents; a later write to a loaded location is
	// snooped so the shadows never go stale without a reload
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			packCfgQ <= `GG_PACK_CFG_RST;
			misc2Q <= `GG_MISC2_RST;
			edv2Q <= `GG_LOW_VOLTAGE_WARNING_RST;
		end else if (clkEn) begin
			if (stateQ == ST_WAIT) begin
				case (loadIdxQ)
				2'd0: packCfgQ <= loadByte;
				2'd1: misc2Q <= loadByte;
				2'd2: edv2Q[15:8] <= loadByte;
				2'd3: edv2Q[7:0] <= loadByte;
				default: packCfgQ <= packCfgQ;
				endcase
			end
			// A write in the same cycle is newer than the fetched byte
			if (dfWrEn) begin
				if (dfWrAddr == `GG_DF_PACK_CFG) begin
					packCfgQ <= dfWrData;
				end
				if (dfWrAddr == `GG_DF_MISC2) begin
					misc2Q <= dfWrData;
				end
				if (dfWrAddr == `GG_DF_LOW_VOLTAGE_WARNING_HI) begin
					edv2Q[15:8] <= dfWrData;
				end
				if (dfWrAddr == `GG_DF_LOW_VOLTAGE_WARNING_LO) begin
					edv2Q[7:0] <= dfWrData;
				end
			end
		end
	end

	// Presence pin: three stages, a change is taken once stages two
	// and three agree, which filters a single-cycle glitch
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			presSync1Q <= 1'b0;
			presSync2Q <= 1'b0;
			presSync3Q <= 1'b0;
			presentQ <= 1'b0;
		end else if (clkEn) begin
			presSync1Q <= packPresentPin;
			presSync2Q <= presSync1Q;
			presSync3Q <= presSync2Q;
			if (presSync2Q == presSync3Q) begin
				presentQ <= presSync3Q;
			end
		end
	end

	// Permanent failure latch: holds between the two flag values
	always @* begin
		permFailD = permFailQ;
		if (failureFlagByte == `GG_FAIL_SET_VAL) begin
			permFailD = 1'b1;
		end else if (failureFlagByte == `GG_FAIL_CLR_VAL) begin
			permFailD = 1'b0;
		end
	end

	always @* begin
		lowVoltD = (monVolt <= edv2Q);
		statusByteD = 8'h00;
		statusByteD[`GG_ST_PRESENT] = presentQ;
		statusByteD[`GG_ST_LOW_VOLT] = lowVoltD;
		statusByteD[`GG_ST_SEALED] = sealed;
		statusByteD[`GG_ST_DSG_QUAL] = dischargeQualified;
		statusByteD[`GG_ST_LINK_FAIL] = frontEndLinkFailed;
		statusByteD[`GG_ST_PERM_FAIL] = permFailD;
		statusByteD[`GG_ST_OVER_LIM] = prolongedOverCurrent | overVoltage | overTemp;
		statusByteD[`GG_ST_UNDER_LIM] = overload | overDischarge;
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			permFailQ <= 1'b0;
			statusWord <= 16'h0000;
		end else if (clkEn) begin
			permFailQ <= permFailD;
			statusWord <= {packCfgQ, statusByteD};
		end
	end

	// Command decode; until the flash is loaded every code is refused.
	// Nothing here writes status or shadows, so a read is harmless.
	always @* begin
		rspAckD = 1'b0;
		rspDataD = 16'h0000;
		if (stateQ == ST_RUN) begin
			case (cmdCls)
			CLS_STATUS: begin
				rspAckD = 1'b1;
				rspDataD = statusWord;
			end
			CLS_CELL: begin
				rspAckD = 1'b1;
				rspDataD = cellPick(cellOfs, cellVolt1, cellVolt2, cellVolt3, cellVolt4);
			end
			CLS_UNSEL: begin
				rspAckD = 1'b0;
			end
			default: begin
				rspAckD = 1'b0;
			end
			endcase
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspAck <= 1'b0;
			rspData <= 16'h0000;
		end else if (clkEn) begin
			rspValid <= cmdValid;
			if (cmdValid) begin
				rspAck <= rspAckD;
				rspData <= rspDataD;
			end
		end
	end

endmodule // gg_pack_status

`default_nettype wire

/* bench/gg_pack_status_monitor.sv */
`default_nettype none
module gg_pack_status_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Gauge inputs
	input wire logic sealed,
	input wire logic [7:0] failureFlagByte,
	input wire logic prolongedOverCurrent,
	input wire logic overVoltage,
	input wire logic overTemp,
	input wire logic overload,
	input wire logic overDischarge,
	// Command port and state
	input wire logic cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic rspValid,
	input wire logic rspAck,
	input wire logic [15:0] rspData,
	input wire logic [15:0] statusWord
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wasEn_q;
	// Keeps one-cycle-late checks off the first edge after reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			wasEn_q <= 1'b0;
		else
			wasEn_q <= clkEn;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_seal_bit: assert property (wasEn_q |-> statusWord[5] == $past(sealed))
		else $error("seal bit wrong");
	a_over_limit: assert property (wasEn_q |-> statusWord[1] == $past(prolongedOverCurrent | overVoltage | overTemp))
		else $error("over-limit bit wrong");
	a_under_limit: assert property (wasEn_q |-> statusWord[0] == $past(overload | overDischarge))
		else $error("under-limit bit wrong");
	a_fail_set: assert property (wasEn_q && $past(failureFlagByte) == 8'h66 |-> statusWord[2])
		else $error("failure bit not set");
	a_fail_hold: assert property (wasEn_q && !($past(failureFlagByte) inside {8'h66, 8'h00}) |-> $stable(statusWord[2]))
		else $error("failure bit moved");
	a_rsp_pulse: assert property (wasEn_q |-> rspValid == $past(cmdValid))
		else $error("response timing wrong");
	a_nack_zero: assert property (rspValid && !rspAck |-> rspData == 16'h0000)
		else $error("refused data not zero");
	a_status_echo: assert property (wasEn_q && rspValid && rspAck && $past(cmdCode) == 8'h2f |-> rspData == $past(statusWord))
		else $error("status word echo wrong");
endmodule // gg_pack_status_monitor

bind gg_pack_status gg_pack_status_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
	.sealed(sealed), .failureFlagByte(failureFlagByte), .prolongedOverCurrent(prolongedOverCurrent),
	.overVoltage(overVoltage), .overTemp(overTemp), .overload(overload), .overDischarge(overDischarge),
	.cmdValid(cmdValid), .cmdCode(cmdCode), .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData),
	.statusWord(statusWord));
`default_nettype wire

/* bench/gg_host_model.sv */
`default_nettype none
module gg_host_model (
	// Clock
	input wire logic sys_clk,
	// Read-word command
	output var logic cmdValid,
	output var logic [7:0] cmdCode,
	input wire logic rspValid,
	input wire logic rspAck,
	input wire logic [15:0] rspData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmdValid = 1'b0;
		cmdCode = 8'h00;
	end
	task automatic readWord(input logic [7:0] c, input int gap, output logic ok, output logic ack, output logic [15:0] d);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		#1;
		cmdValid = 1'b1;
		cmdCode = c;
		@(posedge sys_clk);
		#1;
		cmdValid = 1'b0;
		// Released code lines carry junk so a stale code cannot pass
		cmdCode = ~c;
		// The answer stands only in the cycle after the taking edge
		ok = rspValid;
		ack = rspAck;
		d = rspData;
	endtask
endmodule // gg_host_model
`default_nettype wire

/* bench/tb.sv */
`include "gg_status_defs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, en, pin, wrEn, cmdValid, rspValid, rspAck, cfgLoaded;
	logic [15:0] monPack, rspData, statusWord;
	logic [15:0] cv [1:4];
	logic [7:0] flt, flag, wrAddr, wrData, cmdCode;
	int bad_count, num_checks;
	gg_pack_status i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(en), .packPresentPin(pin),
		.monPackVolt(monPack), .monCellVolt(~monPack), .sealed(flt[7]), .dischargeQualified(flt[6]),
		.frontEndLinkFailed(flt[5]), .failureFlagByte(flag), .prolongedOverCurrent(flt[4]),
		.overVoltage(flt[3]), .overTemp(flt[2]), .overload(flt[1]), .overDischarge(flt[0]),
		.cellVolt1(cv[1]), .cellVolt2(cv[2]), .cellVolt3(cv[3]), .cellVolt4(cv[4]), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData), .dfWrEn(wrEn),
		.dfWrAddr(wrAddr), .dfWrData(wrData), .cfgLoaded(cfgLoaded), .statusWord(statusWord));
	gg_host_model i_host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.rspValid(rspValid), .rspAck(rspAck), .rspData(rspData));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic a, input logic [15:0] d, input int gap = 0);
		logic ok, ack;
		logic [15:0] v;
		i_host.readWord(c, gap, ok, ack, v);
		chk("answer", 16'({a, 1'b1}), 16'({ack, ok}));
		chk("word", d, v);
	endtask
	task automatic dfWr(input logic [7:0] a, input logic [7:0] d);
		wrEn = 1'b1;
		wrAddr = a;
		wrData = d;
		wt(1);
		wrEn = 1'b0;
		wt(2);
	endtask
	// Presence path is the slowest at five cycles
	task automatic bitChk(input int b, input logic e);
		wt(5);
		chk("status bit", 16'(e), 16'(statusWord[b]));
	endtask
	task automatic lv(input logic [15:0] v, input logic e);
		monPack = v;
		bitChk(6, e);
	endtask
	task automatic tBits;
		for (int k = 0; k < 8; k++) begin
			flt = 8'h01 << k;
			rd(`GG_CMD_STATUS, 1'b1, {`GG_PACK_CFG_DFLT, 2'b10, flt[7:5], 1'b0, |flt[4:2], |flt[1:0]});
		end
		flt = 8'h00;
	endtask
	task automatic tCells;
		for (int k = 0; k < 4; k++) begin
			rd(8'h3c + 8'(k), 1'b1, cv[4-k]);
			rd(8'h38 + 8'(k), 1'b0, 16'h0000);
		end
		dfWr(`GG_DF_MISC2, 8'h01);
		for (int k = 0; k < 4; k++) begin
			rd(8'h38 + 8'(k), 1'b1, cv[4-k], k);
			rd(8'h3c + 8'(k), 1'b0, 16'h0000);
		end
		dfWr(`GG_DF_MISC2, 8'h00);
		rd(8'h00, 1'b0, 16'h0000);
	endtask
	task automatic tVolt;
		lv(16'h0d49, 1'b0);
		lv(16'h0d48, 1'b1);
		lv(16'h0d47, 1'b1);
		dfWr(`GG_DF_LOW_VOLTAGE_WARNING_HI, 8'h12);
		dfWr(`GG_DF_LOW_VOLTAGE_WARNING_LO, 8'h34);
		lv(16'h1235, 1'b0);
		lv(16'h1234, 1'b1);
		dfWr(`GG_DF_MISC2, 8'h02);
		lv(16'h1234, 1'b0);
		lv(16'hffff, 1'b1);
		dfWr(`GG_DF_MISC2, 8'h00);
		lv(16'hffff, 1'b0);
	endtask
	task automatic tFail;
		logic [7:0] f [5] = '{8'h66, 8'h12, 8'h00, 8'h12, 8'h66};
		logic [4:0] e = 5'b10011;
		for (int i = 0; i < 5; i++) begin
			flag = f[i];
			bitChk(2, e[i]);
		end
		flag = 8'h00;
	endtask
	task automatic tPres;
		pin = 1'b0;
		bitChk(7, 1'b0);
		pin = 1'b1;
		bitChk(7, 1'b1);
	endtask
	task automatic tPack;
		dfWr(`GG_DF_PACK_CFG, 8'h5a);
		rd(`GG_CMD_STATUS, 1'b1, 16'h5a80);
		rd(`GG_CMD_STATUS, 1'b1, 16'h5a80, 3);
	endtask
	// Enable low must freeze the status word against a changing input
	task automatic tFreeze;
		logic [15:0] w;
		w = statusWord;
		en = 1'b0;
		flt = 8'h80;
		wt(3);
		chk("frozen word", w, statusWord);
		en = 1'b1;
		bitChk(5, 1'b1);
		flt = 8'h00;
		wt(2);
	endtask
	// A second reset must reload the shadows from the written flash
	task automatic tReset;
		rst_n = 1'b0;
		wt(2);
		chk("reset word", 16'h0000, statusWord);
		chk("reset answer", 16'h0000, 16'({rspValid, rspAck}));
		rst_n = 1'b1;
		rd(`GG_CMD_STATUS, 1'b0, 16'h0000);
		wt(8);
		chk("loaded", 16'h0001, 16'(cfgLoaded));
		rd(`GG_CMD_STATUS, 1'b1, 16'h5a80);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		pin = 1'b1;
		wrEn = 1'b0;
		wrAddr = 8'h00;
		wrData = 8'h00;
		monPack = 16'hffff;
		flt = 8'h00;
		flag = 8'h00;
		for (int k = 1; k < 5; k++)
			cv[k] = 16'h0b00 + 16'(k * 273);
		wt(4);
		chk("reset word", 16'h0000, statusWord);
		rst_n = 1'b1;
		rd(`GG_CMD_STATUS, 1'b0, 16'h0000);
		wt(8);
		chk("loaded", 16'h0001, 16'(cfgLoaded));
		tBits();
		tCells();
		tVolt();
		tFail();
		tPres();
		tFreeze();
		tPack();
		tReset();
		results();
	end
	initial begin
		repeat (4000) @(posedge sys_clk);
		bad_count++;
		results();
	end
endmodule // tb
`default_nettype wire
